// ==== logic/fosr_pkg.sv ====
// constants and types shared by the flash status host controller
package fosr_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 22;
  localparam int DATA_W   = 16;
  localparam int CLK_NS   = 20;
  localparam int T_ACC_NS = 70;
  localparam int T_WE_NS  = 35;
  localparam int SYNC_CYC = 2;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC   = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC   = ACC_CYC + SYNC_CYC;

  // ----------------------------------------------------------------
  // software register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;

  // status register bit positions
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_FAIL  = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_TLIM  = 4;
  localparam int ST_NACC  = 5;
  localparam int ST_READY = 6;

  // ----------------------------------------------------------------
  // polling word bit positions
  // ----------------------------------------------------------------
  localparam int PB_POLL   = 7;
  localparam int PB_TOGGLE = 6;
  localparam int PB_TLIM   = 5;
  localparam int PB_ETIMER = 3;
  localparam int PB_ABORT  = 1;

  // ----------------------------------------------------------------
  // device command words and unlock addresses
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_RESET   = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_SR_READ = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_SECT_ER = 16'h0030;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 22'h000555;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 22'h0002AA;

  typedef enum logic [2:0] {
    OP_NONE, OP_WRITE, OP_READ, OP_SR_READ, OP_POLL, OP_ADD_SECTOR
  } fosr_op_t;

endpackage

// ==== logic/fosr_cyc_if.sv ====
// single flash bus cycle request and answer between host core and pin engine
`timescale 1ns/1ps
interface fosr_cyc_if;
  import fosr_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport core (output req, wr, addr, wdata, input done, rdata);
  modport eng  (input req, wr, addr, wdata, output done, rdata);
endinterface

// ==== logic/fosr_bus_cycle.sv ====
// pin engine: runs one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module fosr_bus_cycle (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  // core side
  fosr_cyc_if.eng                     cyc,
  // flash pins
  output logic [fosr_pkg::ADDR_W-1:0] addr_o,
  output logic [fosr_pkg::DATA_W-1:0] dq_o,
  input  wire logic [fosr_pkg::DATA_W-1:0] dq_i,
  output logic                        dq_oe_n_o,
  output logic                        ce_n_o,
  output logic                        oe_n_o,
  output logic                        we_n_o
);
  import fosr_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fosr_cst_t;

  fosr_cst_t         st_reg;
  logic              wr_reg;
  logic [3:0]        cnt_reg;
  logic [DATA_W-1:0] dq_s1_reg;
  logic [DATA_W-1:0] dq_s2_reg;
  logic              done_reg;
  logic [DATA_W-1:0] rdata_reg;

  assign cyc.done  = done_reg;
  assign cyc.rdata = rdata_reg;

  // ----------------------------------------------------------------
  // data pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    dq_s1_reg <= dq_i;
    dq_s2_reg <= dq_s1_reg;
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg    <= C_IDLE;
      wr_reg    <= 1'b0;
      cnt_reg   <= 4'h0;
      done_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
      addr_o    <= 22'h000000;
      dq_o      <= 16'h0000;
      dq_oe_n_o <= 1'b1;
      ce_n_o    <= 1'b1;
      oe_n_o    <= 1'b1;
      we_n_o    <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      case (st_reg)
        C_IDLE: if (cyc.req) begin
          // address and chip enable settle one cycle before the strobe
          wr_reg    <= cyc.wr;
          addr_o    <= cyc.addr;
          dq_o      <= cyc.wdata;
          dq_oe_n_o <= ~cyc.wr;
          ce_n_o    <= 1'b0;
          st_reg    <= C_SETUP;
        end
        C_SETUP: begin
          we_n_o  <= ~wr_reg;
          oe_n_o  <= wr_reg;
          cnt_reg <= wr_reg ? 4'(WE_CYC - 1) : 4'(RD_CYC - 1);
          st_reg  <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt_reg == 4'h0) begin
            // read data sampled after access time plus the sync delay
            if (!wr_reg) rdata_reg <= dq_s2_reg;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            st_reg <= C_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        C_HOLD: begin
          ce_n_o    <= 1'b1;
          dq_oe_n_o <= 1'b1;
          done_reg  <= 1'b1;
          st_reg    <= C_IDLE;
        end
        default: st_reg <= C_IDLE;
      endcase
    end
  end

endmodule // fosr_bus_cycle

// ==== logic/fosr_host.sv ====
// host controller that commands a parallel flash and decodes its status
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
// Behaviour
// - host checks timer before and after adds
// - abort bit set; host sends abort reset
// - host polls at valid operation address
// - failure: host sends reset or clear
module fosr_host (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  // software register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  // flash pins
  output logic [fosr_pkg::ADDR_W-1:0] flash_addr_o,
  output logic [fosr_pkg::DATA_W-1:0] flash_dq_o,
  input  wire logic [fosr_pkg::DATA_W-1:0] flash_dq_i,
  output logic                        flash_dq_oe_n_o,
  output logic                        flash_ce_n_o,
  output logic                        flash_oe_n_o,
  output logic                        flash_we_n_o,
  input  wire logic                   ready_busy_output_i
);
  import fosr_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_WRITE, H_READ, H_SR_CMD, H_SR_RD, H_POLL_A, H_POLL_B,
    H_ADD_PRE, H_ADD_CMD, H_ADD_POST, H_RECOV
  } fosr_hst_t;

  fosr_cyc_if cyc ();

  fosr_hst_t         st_reg;
  logic              go_reg;
  logic              req_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] prev_reg;
  logic              fail_seen_reg;
  logic              rec_abort_reg;
  logic [1:0]        rec_idx_reg;
  logic              done_flag_reg;
  logic              fail_flag_reg;
  logic              abort_flag_reg;
  logic              tlim_flag_reg;
  logic              nacc_flag_reg;
  logic              rb_s1_reg;
  logic              rb_s2_reg;
  logic              start;
  fosr_op_t          op;
  logic              toggling;
  logic              rec_last;

  // ----------------------------------------------------------------
  // pin engine
  // ----------------------------------------------------------------
  fosr_bus_cycle u_cycle (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .cyc       (cyc.eng),
    .addr_o    (flash_addr_o),
    .dq_o      (flash_dq_o),
    .dq_i      (flash_dq_i),
    .dq_oe_n_o (flash_dq_oe_n_o),
    .ce_n_o    (flash_ce_n_o),
    .oe_n_o    (flash_oe_n_o),
    .we_n_o    (flash_we_n_o)
  );

  // recovery word: abort reset is a three-write unlock, else one reset
  function automatic logic [ADDR_W+DATA_W-1:0] rec_word(
    input logic [1:0] idx, input logic ab, input logic [ADDR_W-1:0] a);
    if (!ab) rec_word = {a, CMD_RESET};
    else if (idx == 2'd0) rec_word = {ADR_UNLOCK1, CMD_UNLOCK1};
    else if (idx == 2'd1) rec_word = {ADR_UNLOCK2, CMD_UNLOCK2};
    else rec_word = {ADR_UNLOCK1, CMD_RESET};
  endfunction

  assign start    = reg_wr_i && reg_addr_i == REG_CTRL && st_reg == H_IDLE;
  assign op       = fosr_op_t'(reg_wdata_i[2:0]);
  assign toggling = cyc.rdata[PB_TOGGLE] ^ prev_reg[PB_TOGGLE];
  assign rec_last = rec_abort_reg ? (rec_idx_reg == 2'd2) : 1'b1;
  assign cyc.req  = req_reg;

  // ----------------------------------------------------------------
  // cycle content per state
  // ----------------------------------------------------------------
  always_comb begin
    cyc.wr    = 1'b0;
    cyc.addr  = addr_reg;
    cyc.wdata = data_reg;
    case (st_reg)
      H_WRITE: cyc.wr = 1'b1;
      H_SR_CMD: begin
        cyc.wr    = 1'b1;
        cyc.addr  = ADR_UNLOCK1;
        cyc.wdata = CMD_SR_READ;
      end
      H_ADD_CMD: begin
        cyc.wr    = 1'b1;
        cyc.wdata = CMD_SECT_ER;
      end
      H_RECOV: begin
        cyc.wr = 1'b1;
        {cyc.addr, cyc.wdata} = rec_word(rec_idx_reg, rec_abort_reg,
                                         addr_reg);
      end
      default: cyc.wr = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // ready/busy synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      // reset to the pulled-up idle level so no false busy follows reset
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else begin
      rb_s1_reg <= ready_busy_output_i;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // operand registers, frozen while an operation runs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_reg <= 22'h000000;
      data_reg <= 16'h0000;
    end else if (st_reg == H_IDLE && reg_wr_i) begin
      if (reg_addr_i == REG_ADDR) addr_reg <= reg_wdata_i[ADDR_W-1:0];
      if (reg_addr_i == REG_DATA) data_reg <= reg_wdata_i[DATA_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg         <= H_IDLE;
      go_reg         <= 1'b0;
      req_reg        <= 1'b0;
      result_reg     <= 16'h0000;
      prev_reg       <= 16'h0000;
      fail_seen_reg  <= 1'b0;
      rec_abort_reg  <= 1'b0;
      rec_idx_reg    <= 2'd0;
      done_flag_reg  <= 1'b0;
      fail_flag_reg  <= 1'b0;
      abort_flag_reg <= 1'b0;
      tlim_flag_reg  <= 1'b0;
      nacc_flag_reg  <= 1'b0;
    end else begin
      req_reg <= 1'b0;
      if (st_reg == H_IDLE) begin
        go_reg <= 1'b0;
        if (start && op != OP_NONE) begin
          done_flag_reg  <= 1'b0;
          fail_flag_reg  <= 1'b0;
          abort_flag_reg <= 1'b0;
          tlim_flag_reg  <= 1'b0;
          nacc_flag_reg  <= 1'b0;
          fail_seen_reg  <= 1'b0;
          rec_idx_reg    <= 2'd0;
          case (op)
            OP_WRITE:      st_reg <= H_WRITE;
            OP_READ:       st_reg <= H_READ;
            OP_SR_READ:    st_reg <= H_SR_CMD;
            OP_POLL:       st_reg <= H_POLL_A;
            OP_ADD_SECTOR: st_reg <= H_ADD_PRE;
            default:       st_reg <= H_IDLE;
          endcase
        end
      end else if (!go_reg) begin
        req_reg <= 1'b1;
        go_reg  <= 1'b1;
      end else if (cyc.done) begin
        go_reg <= 1'b0;
        case (st_reg)
          H_SR_CMD: st_reg <= H_SR_RD;
          H_POLL_A: begin
            // first read of the pair is kept as the toggle reference
            prev_reg <= cyc.rdata;
            st_reg   <= H_POLL_B;
          end
          H_POLL_B: begin
            result_reg <= cyc.rdata;
            if (!toggling) begin
              done_flag_reg <= 1'b1;
              st_reg        <= H_IDLE;
            end else if (cyc.rdata[PB_ABORT]) begin
              abort_flag_reg <= 1'b1;
              rec_abort_reg  <= 1'b1;
              st_reg         <= H_RECOV;
            end else if (cyc.rdata[PB_TLIM] && fail_seen_reg) begin
              // toggling survived a recheck after the limit bit rose
              tlim_flag_reg <= 1'b1;
              fail_flag_reg <= 1'b1;
              rec_abort_reg <= 1'b0;
              st_reg        <= H_RECOV;
            end else begin
              fail_seen_reg <= fail_seen_reg | cyc.rdata[PB_TLIM];
              st_reg        <= H_POLL_A;
            end
          end
          H_ADD_PRE: begin
            result_reg <= cyc.rdata;
            if (cyc.rdata[PB_ETIMER]) begin
              // erase already running; the added sector would be lost
              nacc_flag_reg <= 1'b1;
              done_flag_reg <= 1'b1;
              st_reg        <= H_IDLE;
            end else begin
              st_reg <= H_ADD_CMD;
            end
          end
          H_ADD_CMD: st_reg <= H_ADD_POST;
          H_ADD_POST: begin
            result_reg    <= cyc.rdata;
            nacc_flag_reg <= cyc.rdata[PB_ETIMER];
            done_flag_reg <= 1'b1;
            st_reg        <= H_IDLE;
          end
          H_RECOV: begin
            rec_idx_reg <= rec_idx_reg + 2'd1;
            if (rec_last) begin
              done_flag_reg <= 1'b1;
              st_reg        <= H_IDLE;
            end
          end
          default: begin
            result_reg    <= cyc.rdata;
            done_flag_reg <= 1'b1;
            st_reg        <= H_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL:   reg_rdata_o <= {31'h0, st_reg != H_IDLE};
        REG_ADDR:   reg_rdata_o <= {10'h000, addr_reg};
        REG_DATA:   reg_rdata_o <= {16'h0000, data_reg};
        REG_STATUS: reg_rdata_o <= {25'h0, rb_s2_reg, nacc_flag_reg,
                                    tlim_flag_reg, abort_flag_reg,
                                    fail_flag_reg, done_flag_reg,
                                    st_reg != H_IDLE};
        REG_RESULT: reg_rdata_o <= {16'h0000, result_reg};
        default:    reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule // fosr_host

// ==== tb/fosr_host_sva.sv ====
// pin and register port checker for the flash status host controller
`timescale 1ns/1ps
module fosr_host_sva (
  // clock and reset
  input wire logic                        clk_i,
  input wire logic                        sys_rst_i,
  // register port
  input wire logic                        reg_rd_i,
  input wire logic [31:0]                 reg_rdata_o,
  // flash pins
  input wire logic [fosr_pkg::ADDR_W-1:0] flash_addr_o,
  input wire logic [fosr_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic                        flash_dq_oe_n_o,
  input wire logic                        flash_ce_n_o,
  input wire logic                        flash_oe_n_o,
  input wire logic                        flash_we_n_o
);
  import fosr_pkg::*;
  // ------------------------------------------------------------
  // read port idle value and bus cycle shape
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence we_low_s; !flash_we_n_o [*2] ##1 flash_we_n_o; endsequence
  sequence oe_low_s; !flash_oe_n_o [*6] ##1 flash_oe_n_o; endsequence
  rdata_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  we_pulse_a: assert property (
    $fell(flash_we_n_o) |-> we_low_s)
    else $error("write strobe width wrong");
  oe_pulse_a: assert property (
    $fell(flash_oe_n_o) |-> oe_low_s)
    else $error("read strobe width wrong");
  strobe_excl_a: assert property (
    !flash_oe_n_o |-> flash_we_n_o && flash_dq_oe_n_o)
    else $error("read overlaps write or drive");
  we_frame_a: assert property (
    !flash_we_n_o |-> !flash_ce_n_o && !flash_dq_oe_n_o)
    else $error("write strobe outside select");
  addr_hold_a: assert property (
    !flash_ce_n_o && $past(!flash_ce_n_o) |-> $stable(flash_addr_o))
    else $error("address moved inside a cycle");
  dq_hold_a: assert property (
    !flash_we_n_o |-> $stable(flash_dq_o))
    else $error("write data moved under strobe");
  ce_release_a: assert property (
    $rose(flash_oe_n_o) |=> flash_ce_n_o)
    else $error("select not released after read");
  oe_lead_a: assert property (
    $fell(flash_oe_n_o) |-> $past(!flash_ce_n_o))
    else $error("read strobe before select");
endmodule // fosr_host_sva

bind fosr_host fosr_host_sva u_sva (.clk_i, .sys_rst_i, .reg_rd_i,
  .reg_rdata_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_n_o,
  .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o);

// ==== tb/fosr_flash_model.sv ====
// behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
module fosr_flash_model (
  // flash pins
  input  wire logic [fosr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [fosr_pkg::DATA_W-1:0] dq_i,
  output logic      [fosr_pkg::DATA_W-1:0] dq_o,
  input  wire logic                        ce_n_i,
  input  wire logic                        oe_n_i,
  input  wire logic                        we_n_i,
  output logic                             ready_busy_o,
  // scenario control
  input  wire logic                        go_i,
  input  wire logic [1:0]                  mode_i,
  input  wire logic [3:0]                  reads_i,
  input  wire logic                        etimer_i
);
  import fosr_pkg::*;
  // ------------------------------------------------------------
  // device state: 0 array, 1 busy, 2 buffer abort, 3 failure
  // ------------------------------------------------------------
  logic [1:0]  mode_reg = 2'h0;
  logic [3:0]  left_reg = 4'h0;
  logic        tog_reg  = 1'b0;
  logic        srq_reg  = 1'b0;
  logic [15:0] val_reg  = 16'h0;
  logic [15:0] mem [int];
  logic [37:0] wlog [$];
  always @(posedge go_i) begin
    mode_reg = mode_i;
    left_reg = reads_i;
  end
  always @(posedge we_n_i) if (ce_n_i === 1'b0) begin
    wlog.push_back({addr_i, dq_i});
    // only writes made in array mode land; an error-ending reset does not
    if (mode_reg == 2'h0) mem[addr_i] = dq_i;
    if (dq_i == CMD_SR_READ) srq_reg = 1'b1;
    else if (dq_i == CMD_RESET) mode_reg = 2'h0;
    else if (dq_i == CMD_SECT_ER) left_reg = reads_i;
  end
  // status overlays every address while busy or in error
  always @(negedge oe_n_i) if (ce_n_i === 1'b0) begin
    if (srq_reg) begin
      val_reg = (mode_reg == 2'h3) ? 16'h00A0 : 16'h0080;
      srq_reg = 1'b0;
    end else if (mode_reg == 2'h0) begin
      val_reg = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[15:0];
    end else begin
      tog_reg = ~tog_reg;
      val_reg = {9'h0, tog_reg, mode_reg == 2'h3, 1'b0,
                 etimer_i | (mode_reg == 2'h3), tog_reg,
                 mode_reg == 2'h2, 1'b0};
      if (mode_reg == 2'h1) begin
        if (left_reg <= 4'h1) mode_reg = 2'h0;
        else left_reg = left_reg - 4'h1;
      end
    end
  end
  // released bus shows the inverse, no keeper on these lines
  assign dq_o = (!ce_n_i && !oe_n_i) ? val_reg : ~val_reg;
  assign ready_busy_o = (mode_reg == 2'h0);
endmodule // fosr_flash_model

// ==== tb/fosr_host_tb.sv ====
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
module fosr_host_tb;
  import fosr_pkg::*;
  logic              clk_i, sys_rst_i, reg_wr_i, reg_rd_i, rd_seen;
  logic [7:0]        reg_addr_i;
  logic [31:0]       reg_wdata_i, reg_rdata_o, last;
  logic [ADDR_W-1:0] flash_addr_o, a;
  logic [DATA_W-1:0] flash_dq_o, flash_dq_i, mdq, d;
  logic              flash_dq_oe_n_o, flash_ce_n_o, flash_oe_n_o;
  logic              flash_we_n_o, ready_busy_output_i, go, etimer;
  logic [1:0]        mode;
  logic [3:0]        nreads;
  logic [63:0]       notes [$];
  logic [63:0]       note;
  int                n_mismatch, n_tests, k, n;
  fosr_host dut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .flash_addr_o, .flash_dq_o, .flash_dq_i,
    .flash_dq_oe_n_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o,
    .ready_busy_output_i);
  fosr_flash_model m (.addr_i(flash_addr_o), .dq_i(flash_dq_i), .dq_o(mdq),
    .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .ready_busy_o(ready_busy_output_i), .go_i(go), .mode_i(mode),
    .reads_i(nreads), .etimer_i(etimer));
  assign flash_dq_i = !flash_dq_oe_n_o ? flash_dq_o : mdq;
  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // a zero mask notes a read whose value is only used for waiting
  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input logic [31:0] msk);
    notes.push_back({e & msk, msk});
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 last = reg_rdata_o;
  endtask
  task automatic run(input fosr_op_t op, input logic [21:0] ad,
                     input logic [15:0] dat);
    int i;
    wr(REG_ADDR, {10'h0, ad});
    wr(REG_DATA, {16'h0, dat});
    wr(REG_CTRL, 32'(op));
    for (i = 0; i < 400; i++) begin
      rd(REG_STATUS, 32'h0, 32'h0);
      if (last[ST_BUSY] === 1'b0) break;
    end
    if (i == 400) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic dev(input logic [1:0] md, input logic [3:0] nr,
                     input logic et);
    @(posedge clk_i);
    mode <= md;
    nreads <= nr;
    etimer <= et;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic lastw(input int back, input logic [21:0] ea,
                       input logic [15:0] ed);
    check(32'(m.wlog[m.wlog.size() - 1 - back]), {ea[15:0], ed});
  endtask
  // ------------------------------------------------------------
  // result watcher and clock
  // ------------------------------------------------------------
  always @(posedge clk_i) rd_seen <= reg_rd_i;
  always @(negedge clk_i) if (rd_seen === 1'b1) begin
    note = notes.pop_front();
    if (note[31:0] != 32'h0) check(reg_rdata_o & note[31:0], note[63:32]);
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i, go, etimer} = 5'b10000;
    {reg_addr_i, reg_wdata_i, mode, nreads} = '0;
    void'($urandom(82));
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(REG_STATUS, 32'h40, 32'h7F);
    rd(REG_RESULT, 32'h0, 32'hFFFFFFFF);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    for (k = 0; k < 3; k++) begin
      a = 22'($urandom()) | 22'h001000;
      // upper byte set keeps data apart from the command words
      d = 16'($urandom()) | 16'h0100;
      run(OP_WRITE, a, d);
      lastw(0, a, d);
      run(OP_READ, a, 16'h0);
      rd(REG_RESULT, {16'h0, d}, 32'hFFFF);
    end
    run(OP_SR_READ, a, 16'h0);
    rd(REG_RESULT, 32'h80, 32'hFF);
    // busy ends on the second read of a pair, so no pair mixes in data
    dev(2'h1, 4'h2, 1'b0);
    run(OP_POLL, a, 16'h0);
    rd(REG_STATUS, 32'h42, 32'h7F);
    dev(2'h3, 4'h0, 1'b0);
    run(OP_SR_READ, a, 16'h0);
    rd(REG_RESULT, 32'hA0, 32'hFF);
    run(OP_POLL, a, 16'h0);
    rd(REG_STATUS, 32'h14, 32'h1C);
    lastw(0, a, CMD_RESET);
    run(OP_READ, a, 16'h0);
    rd(REG_RESULT, {16'h0, d}, 32'hFFFF);
    dev(2'h2, 4'h0, 1'b0);
    run(OP_POLL, a, 16'h0);
    rd(REG_STATUS, 32'h08, 32'h1C);
    lastw(2, ADR_UNLOCK1, CMD_UNLOCK1);
    lastw(1, ADR_UNLOCK2, CMD_UNLOCK2);
    lastw(0, ADR_UNLOCK1, CMD_RESET);
    dev(2'h1, 4'hF, 1'b0);
    run(OP_ADD_SECTOR, a, 16'h0);
    lastw(0, a, CMD_SECT_ER);
    rd(REG_STATUS, 32'h0, 32'h3C);
    n = m.wlog.size();
    dev(2'h1, 4'hF, 1'b1);
    run(OP_ADD_SECTOR, a, 16'h0);
    check(32'(m.wlog.size()), 32'(n));
    rd(REG_STATUS, 32'h20, 32'h3C);
    dev(2'h0, 4'h0, 1'b0);
    rd(REG_STATUS, 32'h40, 32'h41);
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule // fosr_host_tb
